// ### src/conv_seq_pkg.sv
// Purpose: shared constants for the conversion sequencer
// Assumes: 40 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them, except RESULT_READY_N_RISE_CYC, which is set in cycles
package conv_seq_pkg;
    // ------------------------------------------------------------
    // clock and time
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 40;
    localparam int FIXED_DELAY_NS   = 52000;
    localparam int DELAY_STEP_NS    = 8700;
    localparam int FIXED_DELAY_CYC  = (FIXED_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int DELAY_STEP_CYC   = (DELAY_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int RESULT_READY_N_RISE_CYC    = 16;
    localparam int MAIN_PERIOD_US   = 100000;
    localparam int AUX_LAT0_US      = 121000;
    localparam int AUX_LAT1_US      = 31200;
    localparam int AUX_LAT2_US      = 8710;
    localparam int AUX_LAT3_US      = 4970;
    localparam int AUX_PER0_US      = 100000;
    localparam int AUX_PER1_US      = 10000;
    localparam int AUX_PER2_US      = 2500;
    localparam int AUX_PER3_US      = 1250;
    localparam int MAIN_PERIOD_CYC  = MAIN_PERIOD_US * CLK_MHZ;
    localparam int AUX_LAT0_CYC     = AUX_LAT0_US * CLK_MHZ;
    localparam int AUX_LAT1_CYC     = AUX_LAT1_US * CLK_MHZ;
    localparam int AUX_LAT2_CYC     = AUX_LAT2_US * CLK_MHZ;
    localparam int AUX_LAT3_CYC     = AUX_LAT3_US * CLK_MHZ;
    localparam int AUX_PER0_CYC     = AUX_PER0_US * CLK_MHZ;
    localparam int AUX_PER1_CYC     = AUX_PER1_US * CLK_MHZ;
    localparam int AUX_PER2_CYC     = AUX_PER2_US * CLK_MHZ;
    localparam int AUX_PER3_CYC     = AUX_PER3_US * CLK_MHZ;

    typedef logic [31:0] cnt_t;

    // ------------------------------------------------------------
    // serial command decode
    // ------------------------------------------------------------
    localparam logic [2:0] OP_BIT_IDX      = 3'h6;
    localparam logic [6:0] OP7_MAIN_START  = 7'h04;
    localparam logic [6:0] OP7_MAIN_STOP   = 7'h05;
    localparam logic [6:0] OP7_AUX_START   = 7'h06;
    localparam logic [6:0] OP7_AUX_STOP    = 7'h07;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CONFIG_0      = 8'h00;
    localparam logic [7:0] ADDR_MODE1      = 8'h04;
    localparam logic [7:0] ADDR_INPUT_MUX  = 8'h08;
    localparam logic [7:0] ADDR_AUX_CFG    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    localparam int         RUN_MODE_BIT    = 6;
    localparam int         CHOP_BIT        = 4;
    localparam int         ROT_BIT         = 5;
    localparam logic [7:0] MODE_CONFIG_0_RST       = 8'h00;
    localparam logic [7:0] MODE1_RST       = 8'h01;
    localparam logic [7:0] MUX_RST         = 8'h00;
    localparam logic [1:0] AUX_RATE_RST    = 2'h2;
    localparam logic [7:0] MODE_CONFIG_0_MASK      = 8'h4F;
    localparam logic [7:0] MODE1_MASK      = 8'h37;
endpackage : conv_seq_pkg

// ### src/conv_sequencer.sv
// Purpose: start/stop sequencing and result-ready timing for main and aux converters
// Assumes: start pin and serial pins asynchronous; link clock sampled by sys_clk_i
// Notes:   long counts are top parameters so a bench can shorten them
//
// Behaviour
// R1: host holds start pin low using commands
// R2: run mode bit selects continuous or pulse
// R3: opcode acts on seventh falling serial edge
// R4: 08h/09h start main, 0Ah/0Bh stop main
// R5: 0Ch/0Dh start aux, 0Eh/0Fh stop aux
// R6: host keeps start high four clocks
// R7: host keeps start low four clocks before restart
// R8: pulse mode ready high within two clocks
// R9: early stop prevents conversions after current
// R10: late stop lets current conversion complete
// R11: continuous converts from start until stop
// R12: restart by toggle or stop-start, ready high
// R13: ready goes low when data available
// R14: pulse mode does one conversion then stops
// R15: pulse mode ignores stop during conversion
// R16: aux runs by commands only, pin-independent
// R17: settling periods scale with sinc order
// R18: mux write restarts ongoing conversion
// R19: later conversions at nominal data rate
// R20: first latency from rate and filter
// R21: chop or rotation doubles, both quadruple
// R22: chop or rotation period is latency plus delay
// R23: aux first result latency per rate
// R24: aux rate field selects four rates
// R25: fixed start delay then programmed delay
// R26: start pin synchronised before use
// R27: command wins over pin in same cycle
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module conv_sequencer #(
    parameter int MAIN_PERIOD_CYC = conv_seq_pkg::MAIN_PERIOD_CYC,
    parameter int AUX_LAT0_CYC    = conv_seq_pkg::AUX_LAT0_CYC,
    parameter int AUX_LAT1_CYC    = conv_seq_pkg::AUX_LAT1_CYC,
    parameter int AUX_LAT2_CYC    = conv_seq_pkg::AUX_LAT2_CYC,
    parameter int AUX_LAT3_CYC    = conv_seq_pkg::AUX_LAT3_CYC,
    parameter int AUX_PER0_CYC    = conv_seq_pkg::AUX_PER0_CYC,
    parameter int AUX_PER1_CYC    = conv_seq_pkg::AUX_PER1_CYC,
    parameter int AUX_PER2_CYC    = conv_seq_pkg::AUX_PER2_CYC,
    parameter int AUX_PER3_CYC    = conv_seq_pkg::AUX_PER3_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_pin_i,
    input  wire logic       sclk_i,
    input  wire logic       din_i,
    input  wire logic       cs_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rd_data_o,
    output logic            result_ready_n_o,
    output logic            aux_result_strobe_o
);
    typedef enum logic { M_IDLE, M_BUSY } main_state_e;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic start_lvl;
    logic start_rise;
    logic start_fall;
    logic sclk_fall;
    logic din_lvl;
    logic cs_n_lvl;

    pin_sync u_start_sync (                            // R26
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (start_pin_i),
        .level_o   (start_lvl),
        .rise_o    (start_rise),
        .fall_o    (start_fall)
    );
    pin_sync u_sclk_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (sclk_i),
        .level_o   (),
        .rise_o    (),
        .fall_o    (sclk_fall)
    );
    pin_sync u_din_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (din_i),
        .level_o   (din_lvl),
        .rise_o    (),
        .fall_o    ()
    );
    pin_sync u_cs_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (cs_n_i),
        .level_o   (cs_n_lvl),
        .rise_o    (),
        .fall_o    ()
    );

    // ------------------------------------------------------------
    // command byte capture
    // ------------------------------------------------------------
    logic [2:0] bit_cnt_r;
    logic [5:0] shift_r;
    logic       op_strobe;
    logic [6:0] op7;
    logic       cmd_main_start;
    logic       cmd_main_stop;
    logic       cmd_aux_start;
    logic       cmd_aux_stop;

    assign op_strobe      = sclk_fall & ~cs_n_lvl & (bit_cnt_r == conv_seq_pkg::OP_BIT_IDX); // R3
    assign op7            = {shift_r, din_lvl};
    assign cmd_main_start = op_strobe & (op7 == conv_seq_pkg::OP7_MAIN_START); // R4
    assign cmd_main_stop  = op_strobe & (op7 == conv_seq_pkg::OP7_MAIN_STOP); // R4
    assign cmd_aux_start  = op_strobe & (op7 == conv_seq_pkg::OP7_AUX_START); // R5
    assign cmd_aux_stop   = op_strobe & (op7 == conv_seq_pkg::OP7_AUX_STOP); // R5

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 6'h00;
        end else if (cs_n_lvl) begin
            bit_cnt_r <= 3'h0;
        end else if (sclk_fall) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= {shift_r[4:0], din_lvl};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_config_0_r;
    logic [7:0] mode1_r;
    logic [7:0] mux_r;
    logic [1:0] aux_rate_r;
    logic [7:0] rd_data_r;
    logic [7:0] rd_mux;
    logic       wr_mode_config_0;
    logic       wr_mode1;
    logic       wr_mux;
    logic       wr_aux;
    logic       pulse_mode;
    logic       chop_en;
    logic       rot_en;

    assign wr_mode_config_0   = wr_i & (addr_i == conv_seq_pkg::ADDR_MODE_CONFIG_0);
    assign wr_mode1   = wr_i & (addr_i == conv_seq_pkg::ADDR_MODE1);
    assign wr_mux     = wr_i & (addr_i == conv_seq_pkg::ADDR_INPUT_MUX);
    assign wr_aux     = wr_i & (addr_i == conv_seq_pkg::ADDR_AUX_CFG);
    assign pulse_mode = mode_config_0_r[conv_seq_pkg::RUN_MODE_BIT]; // R2
    assign chop_en    = mode1_r[conv_seq_pkg::CHOP_BIT];
    assign rot_en     = mode1_r[conv_seq_pkg::ROT_BIT];

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_config_0_r    <= conv_seq_pkg::MODE_CONFIG_0_RST;
            mode1_r    <= conv_seq_pkg::MODE1_RST;
            mux_r      <= conv_seq_pkg::MUX_RST;
            aux_rate_r <= conv_seq_pkg::AUX_RATE_RST; // R24
        end else begin
            if (wr_mode_config_0) mode_config_0_r <= wr_data_i & conv_seq_pkg::MODE_CONFIG_0_MASK;
            if (wr_mode1) mode1_r <= wr_data_i & conv_seq_pkg::MODE1_MASK;
            if (wr_mux) mux_r <= wr_data_i;
            if (wr_aux) aux_rate_r <= wr_data_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // latency arithmetic
    // ------------------------------------------------------------
    function automatic conv_seq_pkg::cnt_t filt_order(input logic [2:0] sel);
        conv_seq_pkg::cnt_t ord;
        ord = ((sel >= 3'h2) && (sel <= 3'h5)) ? conv_seq_pkg::cnt_t'(sel) : 32'h0000_0001;
        return ord;
    endfunction : filt_order

    function automatic conv_seq_pkg::cnt_t prog_delay(input logic [3:0] dsel);
        conv_seq_pkg::cnt_t d;
        d = (dsel == 4'h0) ? 32'h0000_0000
            : (conv_seq_pkg::cnt_t'(conv_seq_pkg::DELAY_STEP_CYC) << (dsel - 4'h1));
        return d;
    endfunction : prog_delay

    function automatic conv_seq_pkg::cnt_t aux_first(input logic [1:0] rate);
        conv_seq_pkg::cnt_t v;
        case (rate)
            2'h0:    v = conv_seq_pkg::cnt_t'(AUX_LAT0_CYC);
            2'h1:    v = conv_seq_pkg::cnt_t'(AUX_LAT1_CYC);
            2'h2:    v = conv_seq_pkg::cnt_t'(AUX_LAT2_CYC);
            default: v = conv_seq_pkg::cnt_t'(AUX_LAT3_CYC);
        endcase
        return v;
    endfunction : aux_first

    function automatic conv_seq_pkg::cnt_t aux_period(input logic [1:0] rate);
        conv_seq_pkg::cnt_t v;
        case (rate)
            2'h0:    v = conv_seq_pkg::cnt_t'(AUX_PER0_CYC);
            2'h1:    v = conv_seq_pkg::cnt_t'(AUX_PER1_CYC);
            2'h2:    v = conv_seq_pkg::cnt_t'(AUX_PER2_CYC);
            default: v = conv_seq_pkg::cnt_t'(AUX_PER3_CYC);
        endcase
        return v;
    endfunction : aux_period

    conv_seq_pkg::cnt_t base_lat;
    conv_seq_pkg::cnt_t first_lat;
    conv_seq_pkg::cnt_t next_period;

    assign base_lat    = conv_seq_pkg::cnt_t'(conv_seq_pkg::FIXED_DELAY_CYC) + prog_delay(mode_config_0_r[3:0])
                       + conv_seq_pkg::cnt_t'(filt_order(mode1_r[2:0]) * conv_seq_pkg::cnt_t'(MAIN_PERIOD_CYC)); // R25 R17 R20
    assign first_lat   = (chop_en & rot_en) ? (base_lat << 2)
                       : (chop_en | rot_en) ? (base_lat << 1) : base_lat; // R21
    assign next_period = (chop_en | rot_en) ? base_lat : conv_seq_pkg::cnt_t'(MAIN_PERIOD_CYC); // R22 R19

    // ------------------------------------------------------------
    // main converter control
    // ------------------------------------------------------------
    main_state_e        main_state_r;
    conv_seq_pkg::cnt_t main_cnt_r;
    logic               stop_pend_r;
    logic               result_ready_n_n_r;
    logic               main_busy;
    logic               cmd_any_main;
    logic               main_start_req;
    logic               main_stop_req;
    logic               mux_restart;
    logic               main_go;
    logic               main_done;
    logic               stop_now;
    logic               end_run;

    assign main_busy      = (main_state_r == M_BUSY);
    assign cmd_any_main   = cmd_main_start | cmd_main_stop;
    assign main_start_req = cmd_any_main ? cmd_main_start : start_rise; // R27 R11 R14
    assign main_stop_req  = cmd_any_main ? cmd_main_stop : start_fall; // R27 R11
    assign mux_restart    = wr_mux & main_busy; // R18
    assign main_go        = main_start_req | mux_restart; // R12
    assign main_done      = main_busy & (main_cnt_r == 32'h0000_0001);
    assign stop_now       = main_stop_req & main_busy & ~pulse_mode; // R15
    assign end_run        = main_done & (pulse_mode | stop_pend_r | stop_now); // R14 R9 R10

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_state_r <= M_IDLE;
            main_cnt_r   <= 32'h0000_0000;
        end else begin
            case (main_state_r)
                M_IDLE: begin
                    if (main_go) begin
                        main_state_r <= M_BUSY;
                        main_cnt_r   <= first_lat;
                    end
                end
                M_BUSY: begin
                    if (main_go) begin
                        main_cnt_r <= first_lat; // R12 R18
                    end else if (end_run) begin
                        main_state_r <= M_IDLE;
                        main_cnt_r   <= 32'h0000_0000;
                    end else if (main_done) begin
                        main_cnt_r <= next_period; // R11 R19
                    end else begin
                        main_cnt_r <= main_cnt_r - 32'h0000_0001;
                    end
                end
                default: begin
                    main_state_r <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_pend_r <= 1'b0;
        end else if (main_go | end_run) begin
            stop_pend_r <= 1'b0;
        end else if (stop_now) begin
            stop_pend_r <= 1'b1; // R9 R10
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_ready_n_n_r <= 1'b1;
        end else if (main_go) begin
            result_ready_n_n_r <= 1'b1; // R8 R12
        end else if (main_done) begin
            result_ready_n_n_r <= 1'b0; // R13
        end else if (main_busy && (main_cnt_r == conv_seq_pkg::cnt_t'(conv_seq_pkg::RESULT_READY_N_RISE_CYC))) begin
            result_ready_n_n_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // aux converter control
    // ------------------------------------------------------------
    logic               aux_run_r;
    conv_seq_pkg::cnt_t aux_cnt_r;
    logic               aux_strobe_r;
    logic               aux_done;

    assign aux_done = aux_run_r & (aux_cnt_r == 32'h0000_0001);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_run_r    <= 1'b0;
            aux_cnt_r    <= 32'h0000_0000;
            aux_strobe_r <= 1'b0;
        end else begin
            aux_strobe_r <= aux_done & ~cmd_aux_start & ~cmd_aux_stop;
            if (cmd_aux_start) begin
                aux_run_r <= 1'b1; // R16
                aux_cnt_r <= aux_first(aux_rate_r); // R23 R24
            end else if (cmd_aux_stop) begin
                aux_run_r <= 1'b0; // R16
                aux_cnt_r <= 32'h0000_0000;
            end else if (aux_done) begin
                aux_cnt_r <= aux_period(aux_rate_r);
            end else if (aux_run_r) begin
                aux_cnt_r <= aux_cnt_r - 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    assign rd_mux = (addr_i == conv_seq_pkg::ADDR_MODE_CONFIG_0)     ? mode_config_0_r
                  : (addr_i == conv_seq_pkg::ADDR_MODE1)     ? mode1_r
                  : (addr_i == conv_seq_pkg::ADDR_INPUT_MUX) ? mux_r
                  : (addr_i == conv_seq_pkg::ADDR_AUX_CFG)   ? {6'h00, aux_rate_r}
                  : (addr_i == conv_seq_pkg::ADDR_STATUS)    ? {3'h0, start_lvl, stop_pend_r, result_ready_n_n_r, aux_run_r, main_busy}
                  : 8'h00;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_i ? rd_mux : 8'h00;
        end
    end

    assign rd_data_o           = rd_data_r;
    assign result_ready_n_o    = result_ready_n_n_r;
    assign aux_result_strobe_o = aux_strobe_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_stop_taken;
        main_busy && !pulse_mode && main_stop_req && !main_go && !main_done;
    endsequence
    sequence seq_last_done;
        stop_pend_r && main_done && !main_go;
    endsequence

    AST_READY_HIGH_AFTER_START: assert property (main_go |-> ##[1:2] result_ready_n_o) // R8
        else $error("ready not high after start");
    AST_READY_LOW_ON_DATA: assert property (main_done && !main_go |=> !result_ready_n_o) // R13
        else $error("ready not low when data available");
    AST_PULSE_ONE_SHOT: assert property (main_done && !main_go && pulse_mode |=> main_state_r == M_IDLE) // R14
        else $error("pulse mode kept converting");
    AST_PULSE_STOP_IGNORED: assert property (main_busy && pulse_mode && main_stop_req && !main_go && !main_done
                                             |=> main_busy && !stop_pend_r) // R15
        else $error("stop acted in pulse mode");
    AST_CONT_NEXT_PERIOD: assert property (main_done && !main_go && !end_run
                                           |=> main_busy && main_cnt_r == $past(next_period)) // R19
        else $error("continuous mode did not reload period");
    AST_STOP_FINISHES_CURRENT: assert property (seq_stop_taken |=> stop_pend_r && main_busy) // R10
        else $error("stop cut current conversion");
    AST_STOP_ENDS_RUN: assert property (seq_last_done |=> main_state_r == M_IDLE ##1 !result_ready_n_o) // R9
        else $error("conversion continued after stop");
    AST_CMD_START_MAIN: assert property (cmd_main_start |=> main_busy && main_cnt_r == $past(first_lat)) // R4
        else $error("start command not applied");
    AST_CMD_PRIORITY: assert property (cmd_main_stop && start_rise && main_busy && !pulse_mode && !main_done
                                       |=> stop_pend_r) // R27
        else $error("pin won over command");
    AST_AUX_START: assert property (cmd_aux_start |=> aux_run_r && aux_cnt_r == $past(aux_first(aux_rate_r))) // R23
        else $error("aux start latency wrong");
    AST_AUX_PIN_FREE: assert property ((start_rise || start_fall) && !cmd_aux_start && !cmd_aux_stop
                                       |=> aux_run_r == $past(aux_run_r)) // R16
        else $error("start pin moved aux converter");
    AST_MUX_RESTART: assert property (mux_restart && !cmd_any_main |=> main_cnt_r == $past(first_lat) && result_ready_n_o) // R18
        else $error("mux write did not restart");
    AST_CHOP_BOTH: assert property (main_go && chop_en && rot_en |=> main_cnt_r == ($past(base_lat) << 2)) // R21
        else $error("chop and rotation latency wrong");
    AST_FIXED_DELAY: assert property (main_go |=> main_cnt_r > conv_seq_pkg::cnt_t'(conv_seq_pkg::FIXED_DELAY_CYC)) // R25
        else $error("fixed start delay missing");
    AST_CMD_ON_SEVENTH: assert property (op_strobe |-> !cs_n_lvl ##1 bit_cnt_r == 3'h7) // R3
        else $error("opcode not taken on seventh falling edge");
endmodule : conv_sequencer

// ### src/pin_sync.sv
// Purpose: two-stage synchroniser with edge detection
// Assumes: input is asynchronous to sys_clk_i
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o  = sync_r & ~prev_r;
    assign fall_o  = ~sync_r & prev_r;
endmodule : pin_sync

// ### verification/host_model.sv
// Purpose: host side driving the start pin and serial commands
// Assumes: serial clock period 200 ns, idle low between frames
// Notes:   bits go msb first, the device takes them on falling edges
`timescale 1ns/1ps
module host_model (
    output logic start_pin_o,
    output logic sclk_o,
    output logic din_o,
    output logic cs_n_o
);
    initial begin
        start_pin_o = 1'b0;
        sclk_o      = 1'b0;
        din_o       = 1'b1;
        cs_n_o      = 1'b1;
    end
    // level change, then held past the minimum width
    task automatic pin_set(input logic lv);
        #3;
        start_pin_o = lv;
        #250;
    endtask : pin_set
    // one command byte inside one select frame
    task automatic send_cmd(input logic [7:0] op);
        int i;
        #3;
        cs_n_o = 1'b0;
        #100;
        for (i = 7; i >= 0; i--) begin
            sclk_o = 1'b1;
            din_o  = op[i];
            #100;
            sclk_o = 1'b0;
            #100;
        end
        din_o  = ~din_o;
        cs_n_o = 1'b1;
        #200;
    endtask : send_cmd
endmodule : host_model

// ### verification/tb.sv
// Purpose: self-checking bench for conv_sequencer
// Assumes: host_model drives pin and serial lines
// Notes:   short periods keep the run brief
`timescale 1ns/1ps
module tb;
    localparam int P = 200;
    localparam int L = 2280;
    localparam int LC = 4 * (L + P);
    logic       sys_clk_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdat      = 8'h00;
    logic       wr_s      = 1'b0;
    logic       rd_s      = 1'b0;
    logic       start_pin, sclk, din, cs_n, result_ready_n_o, aux_result_strobe_o;
    logic [7:0] rd_data_o;
    int         err_total = 0, check_count = 0, cyc = 0, aux_cnt = 0;
    conv_sequencer #(.MAIN_PERIOD_CYC(P), .AUX_LAT3_CYC(300), .AUX_PER3_CYC(200))
    u_conv_sequencer (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_pin_i(start_pin), .sclk_i(sclk),
        .din_i(din), .cs_n_i(cs_n), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr_s), .rd_i(rd_s),
        .rd_data_o(rd_data_o), .result_ready_n_o(result_ready_n_o), .aux_result_strobe_o(aux_result_strobe_o));
    host_model u_host_model (.start_pin_o(start_pin), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (aux_result_strobe_o === 1'b1) aux_cnt++;
        if (cyc == 50000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk_i);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk_i);
        rd_s <= 1'b0;
        #1 chk("rd_data", rd_data_o, exp);
    endtask : rd_chk
    task automatic wait_rdy(input logic lv, input int mx, output int n);
        n = 0;
        while (result_ready_n_o !== lv && n < mx) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
    endtask : wait_rdy
    task automatic t_cont(input logic pin);
        int a, b;
        if (pin) u_host_model.pin_set(1'b1);
        else u_host_model.send_cmd(8'h08);
        wait_rdy(1'b1, 100, a);
        wait_rdy(1'b0, L + 100, b);
        chk("first_latency", (b < L + 100) && (a + b > L - 150), 1);
        wait_rdy(1'b1, P, a);
        wait_rdy(1'b0, P, b);
        chk("period", (a + b) inside {[P - 3:P + 3]}, 1);
        repeat (20) @(posedge sys_clk_i);
        if (pin) u_host_model.pin_set(1'b0);
        else u_host_model.send_cmd(8'h0A);
        wait_rdy(1'b1, P, a);
        wait_rdy(1'b0, P, b);
        chk("stop_completes", b < P, 1);
        wait_rdy(1'b1, 3 * P, a);
        chk("no_restart", a, 3 * P);
        $display("test cont pin=%0d done", pin);
    endtask : t_cont
    task automatic t_pulse;
        int a;
        wr(conv_seq_pkg::ADDR_MODE_CONFIG_0, 8'h40);
        rd_chk(conv_seq_pkg::ADDR_MODE_CONFIG_0, 8'h40);
        u_host_model.send_cmd(8'h09);
        chk("ready_high", result_ready_n_o, 1);
        u_host_model.send_cmd(8'h0B);
        wait_rdy(1'b0, L, a);
        chk("pulse_done", a < L, 1);
        wait_rdy(1'b1, 3 * P, a);
        chk("single_shot", a, 3 * P);
        u_host_model.pin_set(1'b1);
        chk("pin_ready_high", result_ready_n_o, 1);
        u_host_model.pin_set(1'b0);
        wait_rdy(1'b0, L, a);
        chk("pin_pulse_done", a < L, 1);
        wr(conv_seq_pkg::ADDR_MODE_CONFIG_0, 8'h00);
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_aux;
        int c;
        wr(conv_seq_pkg::ADDR_AUX_CFG, 8'h03);
        rd_chk(conv_seq_pkg::ADDR_AUX_CFG, 8'h03);
        c = aux_cnt;
        u_host_model.send_cmd(8'h0C);
        u_host_model.pin_set(1'b1);
        u_host_model.pin_set(1'b0);
        repeat (1000) @(posedge sys_clk_i);
        chk("aux_count", (aux_cnt - c) inside {[4:5]}, 1);
        u_host_model.send_cmd(8'h0E);
        c = aux_cnt;
        repeat (600) @(posedge sys_clk_i);
        chk("aux_stopped", aux_cnt - c, 0);
        u_host_model.send_cmd(8'h0D);
        repeat (400) @(posedge sys_clk_i);
        chk("aux_restart", aux_cnt - c, 1);
        u_host_model.send_cmd(8'h0F);
        $display("test aux done");
    endtask : t_aux
    task automatic t_mux;
        int a, b;
        wr(conv_seq_pkg::ADDR_MODE1, 8'h32);
        u_host_model.send_cmd(8'h08);
        wait_rdy(1'b1, 100, a);
        wait_rdy(1'b0, LC + 100, b);
        chk("chop_rot_latency", (b > LC - 200) && (b < LC + 100), 1);
        wr(conv_seq_pkg::ADDR_INPUT_MUX, 8'h05);
        wait_rdy(1'b1, 4, a);
        chk("mux_restart", a < 4, 1);
        wait_rdy(1'b0, LC + 100, b);
        chk("mux_latency", (b > LC - 100) && (b < LC + 100), 1);
        u_host_model.send_cmd(8'h0A);
        $display("test mux done");
    endtask : t_mux
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk("ready_rst", result_ready_n_o, 1);
        rd_chk(conv_seq_pkg::ADDR_MODE_CONFIG_0, conv_seq_pkg::MODE_CONFIG_0_RST);
        rd_chk(conv_seq_pkg::ADDR_MODE1, conv_seq_pkg::MODE1_RST);
        rd_chk(8'h20, 8'h00);
        t_cont(1'b1);
        t_cont(1'b0);
        t_pulse();
        t_aux();
        t_mux();
        final_report();
    end
endmodule : tb
